// ===== hdl/lds_steer.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - single reads fetch only requested byte lanes
// - burst reads transfer every byte lane
// - burst reads configurable: prefetch, waits, ack, type
// - writes touch only the specified bytes
// - narrow port splits word into several cycles
// - each split cycle encodes its size code
// - parity check never alters any transfer
// - one parity bit per lane, optional locally
// - drive even parity whenever device drives data
// - check parity on target, master-write, dma reads
// - parity error sets status bit seven
// - interrupt only when both enables are set
// - flag appears the cycle after sampling
// - addresses use plain 32-bit little-endian map
// - endianness per phase type from config and pin
// - fixed pin and cycle per bit, reversible
// - 32-bit little: bit k to pin 31-k
// - 16-bit little: halfwords in order, reversed
// - 32-bit big: bytes keep lane, bits reversed
// - 16-bit big: low byte 23-j, high 31-j
// - 8-bit: byte b in cycle b+1, reversed
module lds_steer (
  input wire logic clock,
  input wire logic rst,
  input wire logic req_valid,
  output logic req_ready,
  input wire lds_pkg::lds_req_t req,
  output logic resp_valid,
  output logic [31:0] resp_data,
  input wire lds_pkg::lds_width_t port_width,
  input wire logic [3:0] endian_config,
  input wire logic endian_select_pin_n,
  input wire lds_pkg::lds_burst_cfg_t burst_cfg,
  output logic local_start,
  output logic [31:0] local_addr,
  output logic local_write,
  output logic [3:0] local_be,
  output logic [1:0] transfer_size_code,
  output lds_pkg::lds_burst_attr_t burst_attr,
  output logic [31:0] local_data_pin_out,
  input wire logic [31:0] local_data_pin_in,
  output logic local_data_oe,
  output logic [3:0] lane_parity_out,
  input wire logic [3:0] lane_parity_in,
  output logic lane_parity_oe,
  input wire logic transfer_ack_n,
  input wire logic lm_cfg,
  input wire logic lm_wr_strobe,
  output logic lm_wr_valid,
  output logic [31:0] lm_wr_data,
  input wire logic lm_rd_drive,
  input wire logic [31:0] lm_rd_data,
  input wire logic local_irq_en,
  input wire logic parity_irq_en,
  input wire logic parity_err_clear,
  output logic [31:0] irq_control_status,
  output logic local_irq_out_n
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [2:0] ack_sync_reg;
  logic [2:0] pin_sync_reg;
  logic ack_n_reg;
  logic pin_n_reg;

  // a change counts only once stages two and three agree
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      ack_sync_reg <= {3{lds_pkg::LDS_ACK_N_RESET}};
      ack_n_reg <= lds_pkg::LDS_ACK_N_RESET;
    end
    else
    begin
      ack_sync_reg <= {ack_sync_reg[1:0], transfer_ack_n};
      if (ack_sync_reg[1] == ack_sync_reg[2])
        ack_n_reg <= ack_sync_reg[2];
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pin_sync_reg <= {3{lds_pkg::LDS_PIN_N_RESET}};
      pin_n_reg <= lds_pkg::LDS_PIN_N_RESET;
    end
    else
    begin
      pin_sync_reg <= {pin_sync_reg[1:0], endian_select_pin_n};
      if (pin_sync_reg[1] == pin_sync_reg[2])
        pin_n_reg <= pin_sync_reg[2];
    end
  end

  // ------------------------------------------------------------
  // cycle sequencing
  // ------------------------------------------------------------
  typedef enum logic [1:0] {S_IDLE, S_START, S_DATA} lds_state_t;

  lds_state_t state_reg;
  lds_pkg::lds_req_t req_reg;
  lds_pkg::lds_width_t width_reg;
  logic [3:0] be_reg;
  logic [1:0] chunk_reg;
  logic [3:0] wcnt_reg;
  logic big_reg;
  logic ta_en_reg;
  logic [31:0] acc_reg;
  logic [3:0] cur_be;
  logic [2:0] first_hit;
  logic [2:0] next_hit;
  logic [3:0] eff_be;
  logic done;
  logic [31:0] to_local;
  logic [31:0] to_pci;
  logic [3:0] lane_en;
  logic big_now;

  // first chunk at or after 'from' holding an enabled byte; msb says found
  function automatic logic [2:0] find_chunk(input logic [3:0] be, input lds_pkg::lds_width_t w,
                                            input logic [2:0] from);
    find_chunk = 3'b000;
    for (int c = 3; c >= 0; c--)
      if (3'(c) >= from && |lds_pkg::chunk_be(be, w, 2'(c)))
        find_chunk = {1'b1, 2'(c)};
  endfunction

  // per phase type the config bit picks big endian, the pin can force it
  assign big_now = endian_config[req.path] | ~pin_n_reg;

  // burst reads pass every lane; single reads and all writes keep the enables
  assign eff_be = (req.burst && !req.write) ? lds_pkg::LDS_ALL_LANES : req.byte_en;
  assign first_hit = find_chunk(eff_be, port_width, 3'b000);
  assign cur_be = lds_pkg::chunk_be(be_reg, width_reg, chunk_reg);
  assign next_hit = find_chunk(be_reg, width_reg, 3'({1'b0, chunk_reg} + 3'b001));
  assign req_ready = (state_reg == S_IDLE);

  // ack enabled: wait for the pin; otherwise count the programmed waits
  assign done = (state_reg == S_DATA) && (ta_en_reg ? !ack_n_reg : (wcnt_reg == 4'h0));

  lds_lane_xlate lds_lane_xlate_i (
    .width(width_reg),
    .big(big_reg),
    .chunk(chunk_reg),
    .pci_word(req_reg.data),
    .byte_en(cur_be),
    .loc_word(local_data_pin_in),
    .to_local(to_local),
    .lane_en(lane_en),
    .to_pci(to_pci)
  );

  // state and transfer context
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_reg <= S_IDLE;
      req_reg <= '0;
      width_reg <= lds_pkg::LDS_W32;
      be_reg <= 4'h0;
      chunk_reg <= 2'h0;
      big_reg <= 1'b0;
      ta_en_reg <= 1'b0;
    end
    else
    begin
      unique case (state_reg)
        S_IDLE:
          if (req_valid && first_hit[2])
          begin
            req_reg <= req;
            width_reg <= port_width;
            be_reg <= eff_be;
            chunk_reg <= first_hit[1:0];
            big_reg <= big_now;
            ta_en_reg <= burst_cfg.ta_enable;
            state_reg <= S_START;
          end
        S_START:
          state_reg <= S_DATA;
        S_DATA:
          // parity never feeds this decision, so errors cannot stall a cycle
          if (done)
          begin
            if (next_hit[2])
            begin
              chunk_reg <= next_hit[1:0];
              state_reg <= S_START;
            end
            else
              state_reg <= S_IDLE;
          end
      endcase
    end
  end

  // wait-state counter, reloaded at each address phase
  always_ff @(posedge clock)
  begin
    if (rst)
      wcnt_reg <= 4'h0;
    else if (state_reg == S_START)
      wcnt_reg <= burst_cfg.wait_count;
    else if (state_reg == S_DATA && wcnt_reg != 4'h0)
      wcnt_reg <= wcnt_reg - 4'h1;
  end

  // ------------------------------------------------------------
  // local bus outputs
  // ------------------------------------------------------------
  logic [1:0] low_byte;

  always_comb
  begin
    low_byte = 2'h3;
    for (int i = 3; i >= 0; i--)
      if (cur_be[i])
        low_byte = 2'(i);
  end

  // address, lanes and size are set up in the address phase and held
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      local_start <= 1'b0;
      local_addr <= 32'h00000000;
      local_write <= 1'b0;
      local_be <= 4'h0;
      transfer_size_code <= 2'h0;
      burst_attr <= '0;
    end
    else
    begin
      local_start <= (state_reg == S_START);
      if (state_reg == S_START)
      begin
        local_addr <= lds_pkg::rev32({req_reg.addr[31:2], low_byte});
        local_write <= req_reg.write;
        local_be <= lane_en;
        transfer_size_code <= 2'($countones(cur_be));
        burst_attr.burst <= req_reg.burst;
        burst_attr.continuous <= req_reg.burst & burst_cfg.continuous;
        burst_attr.prefetch <= req_reg.burst & !req_reg.write & burst_cfg.prefetch;
        burst_attr.read_ahead <= req_reg.burst & !req_reg.write & burst_cfg.read_ahead
                                 & (req_reg.path == lds_pkg::LDS_PATH_TGT);
      end
      else if (state_reg == S_IDLE)
        local_be <= 4'h0;
    end
  end

  // data pins driven for master writes, or for a local master reading us
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      local_data_pin_out <= 32'h00000000;
      local_data_oe <= 1'b0;
      lane_parity_out <= 4'h0;
      lane_parity_oe <= 1'b0;
    end
    else if (state_reg == S_START && req_reg.write)
    begin
      local_data_pin_out <= to_local;
      local_data_oe <= 1'b1;
      lane_parity_out <= lds_pkg::parity32(to_local);
      lane_parity_oe <= 1'b1;
    end
    else if (state_reg == S_IDLE && lm_rd_drive)
    begin
      local_data_pin_out <= lds_pkg::steer32(lm_rd_data, endian_config[lm_cfg ? 3 : 2] | ~pin_n_reg);
      local_data_oe <= 1'b1;
      lane_parity_out <= lds_pkg::parity32(lds_pkg::steer32(lm_rd_data,
                                                            endian_config[lm_cfg ? 3 : 2] | ~pin_n_reg));
      lane_parity_oe <= 1'b1;
    end
    else if (!(state_reg == S_DATA && req_reg.write && !done))
    begin
      local_data_oe <= 1'b0;
      lane_parity_oe <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // read assembly and local master writes
  // ------------------------------------------------------------
  logic [31:0] byte_mask;
  assign byte_mask = {{8{cur_be[3]}}, {8{cur_be[2]}}, {8{cur_be[1]}}, {8{cur_be[0]}}};

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      acc_reg <= 32'h00000000;
      resp_valid <= 1'b0;
      resp_data <= 32'h00000000;
    end
    else
    begin
      resp_valid <= 1'b0;
      if (state_reg == S_IDLE && req_valid && !first_hit[2])
        resp_valid <= 1'b1;
      if (state_reg == S_IDLE)
        acc_reg <= 32'h00000000;
      else if (done)
      begin
        acc_reg <= acc_reg | (to_pci & byte_mask);
        if (!next_hit[2])
        begin
          resp_valid <= 1'b1;
          resp_data <= req_reg.write ? 32'h00000000 : (acc_reg | (to_pci & byte_mask));
        end
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      lm_wr_valid <= 1'b0;
      lm_wr_data <= 32'h00000000;
    end
    else
    begin
      lm_wr_valid <= lm_wr_strobe;
      if (lm_wr_strobe)
        lm_wr_data <= lds_pkg::steer32(local_data_pin_in, endian_config[lm_cfg ? 3 : 2] | ~pin_n_reg);
    end
  end

  // ------------------------------------------------------------
  // parity check, status and interrupt
  // ------------------------------------------------------------
  logic chk_sample;
  logic chk_err;
  logic flag_reg;

  // lanes with no enable carry nothing, so they are not checked;
  // a cycle closed by the wait counter is checked only if ack is held low
  assign chk_sample = (done && !req_reg.write && !ack_n_reg
                       && (req_reg.path == lds_pkg::LDS_PATH_TGT || req_reg.path == lds_pkg::LDS_PATH_DMA))
                      || (lm_wr_strobe && !ack_n_reg);
  assign chk_err = chk_sample
                   && |((lds_pkg::parity32(local_data_pin_in) ^ lane_parity_in) & (lm_wr_strobe ? 4'hF : lane_en));

  // set wins over a clear in the same cycle
  always_ff @(posedge clock)
  begin
    if (rst)
      flag_reg <= lds_pkg::LDS_FLAG_RESET;
    else if (chk_err)
      flag_reg <= 1'b1;
    else if (parity_err_clear)
      flag_reg <= 1'b0;
  end

  always_comb
  begin
    irq_control_status = 32'h00000000;
    irq_control_status[lds_pkg::LDS_LOCAL_IRQ_EN_BIT] = local_irq_en;
    irq_control_status[lds_pkg::LDS_PARITY_IRQ_EN_BIT] = parity_irq_en;
    irq_control_status[lds_pkg::LDS_PARITY_ERR_BIT] = flag_reg;
  end

  assign local_irq_out_n = !(flag_reg && local_irq_en && parity_irq_en);

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  logic [4:0] data_cnt_reg;

  always_ff @(posedge clock)
  begin
    if (rst || state_reg != S_DATA)
      data_cnt_reg <= 5'h00;
    else if (data_cnt_reg != 5'h1F)
      data_cnt_reg <= data_cnt_reg + 5'h01;
  end

  sequence s_last_done;
    done && !next_hit[2];
  endsequence

  sequence s_bad_sample;
    chk_err && !parity_err_clear;
  endsequence

  property p_burst_all_lanes;
    @(posedge clock) disable iff (rst)
      (state_reg == S_DATA && req_reg.burst && !req_reg.write && width_reg == lds_pkg::LDS_W32) |-> local_be == 4'hF;
  endproperty
  a_burst_all_lanes: assert property (p_burst_all_lanes) else $error("burst read lost lanes");

  property p_lane_count;
    @(posedge clock) disable iff (rst)
      state_reg == S_DATA |-> $countones(local_be) == $countones(cur_be);
  endproperty
  a_lane_count: assert property (p_lane_count) else $error("lane enables disagree with bytes");

  property p_size_code;
    @(posedge clock) disable iff (rst)
      state_reg == S_DATA |-> transfer_size_code == 2'($countones(cur_be));
  endproperty
  a_size_code: assert property (p_size_code) else $error("size code wrong");

  property p_parity_out;
    @(posedge clock) disable iff (rst)
      lane_parity_oe |-> local_data_oe && !(^{local_data_pin_out[7:0], lane_parity_out[0]})
                         && !(^{local_data_pin_out[15:8], lane_parity_out[1]})
                         && !(^{local_data_pin_out[23:16], lane_parity_out[2]})
                         && !(^{local_data_pin_out[31:24], lane_parity_out[3]});
  endproperty
  a_parity_out: assert property (p_parity_out) else $error("driven parity not even");

  property p_flag_next;
    @(posedge clock) disable iff (rst)
      s_bad_sample |=> flag_reg ##1 (flag_reg || $past(parity_err_clear));
  endproperty
  a_flag_next: assert property (p_flag_next) else $error("parity flag late");

  property p_irq;
    @(posedge clock) disable iff (rst)
      s_bad_sample ##1 (local_irq_en && parity_irq_en) |-> !local_irq_out_n;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");

  property p_wait_count;
    @(posedge clock) disable iff (rst)
      (done && !ta_en_reg) |-> data_cnt_reg == {1'b0, burst_cfg.wait_count};
  endproperty
  a_wait_count: assert property (p_wait_count) else $error("wait states miscounted");

  property p_resp_after_last;
    @(posedge clock) disable iff (rst)
      s_last_done |=> resp_valid && state_reg == S_IDLE;
  endproperty
  a_resp_after_last: assert property (p_resp_after_last) else $error("no answer after last cycle");

  property p_endian_stable;
    @(posedge clock) disable iff (rst)
      (state_reg != S_IDLE && $past(state_reg) != S_IDLE) |-> $stable(big_reg);
  endproperty
  a_endian_stable: assert property (p_endian_stable) else $error("endian changed mid transfer");

endmodule
`default_nettype wire

// ===== pkg/lds_pkg.sv
`default_nettype none
package lds_pkg;

  // ------------------------------------------------------------
  // status word bit positions and reset values
  // ------------------------------------------------------------
  localparam int LDS_LOCAL_IRQ_EN_BIT = 16;
  localparam int LDS_PARITY_IRQ_EN_BIT = 6;
  localparam int LDS_PARITY_ERR_BIT = 7;
  localparam logic LDS_FLAG_RESET = 1'b0;
  localparam logic LDS_ACK_N_RESET = 1'b1;
  localparam logic LDS_PIN_N_RESET = 1'b1;
  localparam logic [3:0] LDS_ALL_LANES = 4'hF;
  localparam int LDS_SYNC_STAGES = 3;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {LDS_W32, LDS_W16, LDS_W8} lds_width_t;
  typedef enum logic [1:0] {LDS_PATH_TGT, LDS_PATH_DMA, LDS_PATH_LM, LDS_PATH_CFG} lds_path_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0] byte_en;
    logic write;
    logic burst;
    lds_path_t path;
  } lds_req_t;

  typedef struct packed {
    logic prefetch;
    logic read_ahead;
    logic ta_enable;
    logic continuous;
    logic [3:0] wait_count;
  } lds_burst_cfg_t;

  typedef struct packed {
    logic burst;
    logic continuous;
    logic prefetch;
    logic read_ahead;
  } lds_burst_attr_t;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] rev8(input logic [7:0] b);
    for (int i = 0; i < 8; i++)
      rev8[i] = b[7-i];
  endfunction

  function automatic logic [31:0] rev32(input logic [31:0] w);
    rev32 = {rev8(w[7:0]), rev8(w[15:8]), rev8(w[23:16]), rev8(w[31:24])};
  endfunction

  // one-cycle 32-bit port steering; each form is its own inverse
  function automatic logic [31:0] steer32(input logic [31:0] w, input logic big);
    steer32 = big ? {rev8(w[31:24]), rev8(w[23:16]), rev8(w[15:8]), rev8(w[7:0])} : rev32(w);
  endfunction

  // lane bit that makes the nine bits even
  function automatic logic parity8(input logic [7:0] b);
    parity8 = ^b;
  endfunction

  function automatic logic [3:0] parity32(input logic [31:0] w);
    for (int i = 0; i < 4; i++)
      parity32[i] = parity8(w[8*i +: 8]);
  endfunction

  // bytes of the pci word carried by local cycle c
  function automatic logic [3:0] chunk_be(input logic [3:0] be, input lds_width_t w, input logic [1:0] c);
    unique case (w)
      LDS_W32: chunk_be = (c == 2'h0) ? be : 4'h0;
      LDS_W16: chunk_be = (c == 2'h0) ? (be & 4'h3) : ((c == 2'h1) ? (be & 4'hC) : 4'h0);
      default: chunk_be = be & (4'h1 << c);
    endcase
  endfunction

endpackage
`default_nettype wire

// ===== hdl/lds_lane_xlate.sv
`timescale 1ns/1ps
`default_nettype none
// places one pci word slice on the local pins for a given cycle, and back
module lds_lane_xlate (
  input wire lds_pkg::lds_width_t width,
  input wire logic big,
  input wire logic [1:0] chunk,
  input wire logic [31:0] pci_word,
  input wire logic [3:0] byte_en,
  input wire logic [31:0] loc_word,
  output logic [31:0] to_local,
  output logic [3:0] lane_en,
  output logic [31:0] to_pci
);

  // ------------------------------------------------------------
  // pci to local placement
  // ------------------------------------------------------------
  function automatic logic [31:0] place(input logic [31:0] w, input lds_pkg::lds_width_t wd,
                                        input logic bg, input logic [1:0] c);
    logic [15:0] h;
    logic [7:0] b;
    h = c[0] ? w[31:16] : w[15:0];
    b = w[8*c +: 8];
    unique case (wd)
      lds_pkg::LDS_W32: place = lds_pkg::steer32(w, bg);
      lds_pkg::LDS_W16: place = bg ? {lds_pkg::rev8(h[15:8]), lds_pkg::rev8(h[7:0]), 16'h0000}
                                   : {lds_pkg::rev8(h[7:0]), lds_pkg::rev8(h[15:8]), 16'h0000};
      default: place = {lds_pkg::rev8(b), 24'h000000};
    endcase
  endfunction

  // ------------------------------------------------------------
  // local to pci, the same map read backwards
  // ------------------------------------------------------------
  function automatic logic [31:0] unplace(input logic [31:0] l, input lds_pkg::lds_width_t wd,
                                          input logic bg, input logic [1:0] c);
    logic [15:0] h;
    logic [7:0] b;
    h = bg ? {lds_pkg::rev8(l[31:24]), lds_pkg::rev8(l[23:16])}
           : {lds_pkg::rev8(l[23:16]), lds_pkg::rev8(l[31:24])};
    b = lds_pkg::rev8(l[31:24]);
    unique case (wd)
      lds_pkg::LDS_W32: unplace = lds_pkg::steer32(l, bg);
      lds_pkg::LDS_W16: unplace = c[0] ? {h, 16'h0000} : {16'h0000, h};
      default: unplace = 32'({24'h000000, b} << {c, 3'b000});
    endcase
  endfunction

  logic [31:0] mask_local;

  // byte enables ride through the same map to find the local lanes
  always_comb
  begin
    to_local = place(pci_word, width, big, chunk);
    mask_local = place({{8{byte_en[3]}}, {8{byte_en[2]}}, {8{byte_en[1]}}, {8{byte_en[0]}}}, width, big, chunk);
    for (int i = 0; i < 4; i++)
      lane_en[i] = |mask_local[8*i +: 8];
    to_pci = unplace(loc_word, width, big, chunk);
  end

endmodule
`default_nettype wire

// ===== tb/lds_local_mem.sv
`timescale 1ns/1ps
`default_nettype none
// far-side memory: answers read cycles with a fixed image
module lds_local_mem (
  input wire logic clock,
  input wire logic rst,
  input wire logic local_start,
  input wire logic local_write,
  input wire logic resp_valid,
  input wire logic [31:0] image,
  input wire logic [3:0] bad_lanes,
  output logic [31:0] local_data_pin_in,
  output logic [3:0] lane_parity_in,
  output logic transfer_ack_n
);
  logic act_reg;
  logic tog_reg;
  // ack held low even with ack disabled, else checks are lost
  assign transfer_ack_n = 1'b0;
  // read window from address phase to the answer
  always_ff @(posedge clock)
  begin
    tog_reg <= rst ? 1'b0 : ~tog_reg;
    if (rst || resp_valid)
      act_reg <= 1'b0;
    else if (local_start && !local_write)
      act_reg <= 1'b1;
  end
  // released bus alternates each cycle between the inverted image and the image itself
  assign local_data_pin_in = ((local_start && !local_write) || act_reg) ? image : ~image ^ {32{tog_reg}};
  // even lane parity, one bit per lane; bad_lanes spoils it on command
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      lane_parity_in[i] = ^local_data_pin_in[8*i +: 8] ^ bad_lanes[i];
  end
endmodule
`default_nettype wire

// ===== tb/local_bus_data_lane_steering_tb.sv
`timescale 1ns/1ps
`default_nettype none
module local_bus_data_lane_steering_tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  lds_pkg::lds_req_t req = '0;
  lds_pkg::lds_width_t port_width = lds_pkg::LDS_W32;
  logic [3:0] endian_config = 4'h0;
  lds_pkg::lds_burst_cfg_t burst_cfg = '0;
  logic zero = 1'b0;
  logic [31:0] image = 32'h1234ABCD;
  logic [3:0] bad = 4'h0;
  logic irq_en = 1'b0;
  logic par_en = 1'b0;
  logic clr = 1'b0;
  logic pin_n = 1'b1;
  logic req_ready, resp_valid, local_start, local_write, ack_n, irq_n;
  logic [31:0] resp_data, pins, pin_in, status;
  logic [3:0] lbe, lpo, lpi;
  logic [1:0] size;
  logic [31:0] pq[4];
  logic [3:0] bq[4];
  logic [3:0] lq[4];
  logic [1:0] sq[4];
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int ns;
  int nk;
  lds_steer lds_steer_i (.clock(clock), .rst(rst), .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .resp_valid(resp_valid), .resp_data(resp_data), .port_width(port_width), .endian_config(endian_config),
    .endian_select_pin_n(pin_n), .burst_cfg(burst_cfg), .local_start(local_start), .local_addr(),
    .local_write(local_write), .local_be(lbe), .transfer_size_code(size), .burst_attr(),
    .local_data_pin_out(pins), .local_data_pin_in(pin_in), .local_data_oe(), .lane_parity_out(lpo),
    .lane_parity_in(lpi), .lane_parity_oe(), .transfer_ack_n(ack_n), .lm_cfg(zero), .lm_wr_strobe(zero),
    .lm_wr_valid(), .lm_wr_data(), .lm_rd_drive(zero), .lm_rd_data(32'h0), .local_irq_en(irq_en),
    .parity_irq_en(par_en), .parity_err_clear(clr), .irq_control_status(status), .local_irq_out_n(irq_n));
  lds_local_mem lds_local_mem_i (.clock(clock), .rst(rst), .local_start(local_start), .local_write(local_write),
    .resp_valid(resp_valid), .image(image), .bad_lanes(bad), .local_data_pin_in(pin_in),
    .lane_parity_in(lpi), .transfer_ack_n(ack_n));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // own mirror of the word, kept apart from the design's helpers
  function automatic logic [31:0] rv(input logic [31:0] x);
    for (int i = 0; i < 32; i++)
      rv[i] = x[31-i];
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // one request; records every local cycle up to the answer
  task automatic xfer(input lds_pkg::lds_width_t w, input logic wr, input logic bu, input logic [3:0] be,
    input logic [31:0] d);
    int k;
    k = 0;
    ns = 0;
    port_width <= w;
    req_valid <= 1'b1;
    req <= '{addr: 32'h00001000, data: d, byte_en: be, write: wr, burst: bu, path: lds_pkg::LDS_PATH_TGT};
    do
    begin
      @(posedge clock);
      k++;
    end while (req_ready !== 1'b1 && k < 50);
    req_valid <= 1'b0;
    while (resp_valid !== 1'b1 && k < 200)
    begin
      @(posedge clock);
      k++;
      if (local_start === 1'b1 && ns < 4)
      begin
        pq[ns] = pins;
        bq[ns] = lbe;
        lq[ns] = lpo;
        sq[ns] = size;
        ns++;
      end
    end
    nk = k;
    chk("answer", 32'h1, {31'h0, resp_valid});
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_wr32();
    xfer(lds_pkg::LDS_W32, 1'b1, 1'b0, 4'h6, 32'hA5C13C5A);
    chk("cycles", 32'h1, 32'(ns));
    chk("pins", rv(32'hA5C13C5A) & 32'h00FFFF00, pq[0] & 32'h00FFFF00);
    chk("lanes", 32'h6, 32'(bq[0]));
    chk("size", 32'h2, 32'(sq[0]));
    chk("parity", 32'h2, 32'(lq[0] & 4'h6));
    endian_config <= 4'h1;
    xfer(lds_pkg::LDS_W32, 1'b1, 1'b0, 4'hF, 32'hA5C33C5A);
    chk("big pins", rv(32'h5A3CC3A5), pq[0]);
    chk("big size", 32'h0, 32'(sq[0]));
    endian_config <= 4'h0;
    $display("t_wr32 done");
  endtask
  task automatic t_narrow();
    xfer(lds_pkg::LDS_W8, 1'b1, 1'b0, 4'h5, 32'h00C40081);
    chk("w8 cycles", 32'h2, 32'(ns));
    chk("w8 b0", 32'h81, 32'(rv({pq[0][31:24], 24'h0})));
    chk("w8 b2", 32'hC4, 32'(rv({pq[1][31:24], 24'h0})));
    chk("w8 lanes", 32'h88, {24'h0, bq[0], bq[1]});
    chk("w8 size", 32'h5, {28'h0, sq[0], sq[1]});
    xfer(lds_pkg::LDS_W16, 1'b1, 1'b0, 4'hF, 32'hB00D1234);
    chk("w16 cycles", 32'h2, 32'(ns));
    chk("w16 pins", rv(32'hB00D1234), {pq[0][31:16], 16'h0} ^ {16'h0, pq[1][31:16]});
    chk("w16 size", 32'hA, {28'h0, sq[0], sq[1]});
    $display("t_narrow done");
  endtask
  task automatic t_rd();
    xfer(lds_pkg::LDS_W32, 1'b0, 1'b0, 4'h3, 32'h0);
    chk("single read", rv(32'h1234ABCD) & 32'h0000FFFF, resp_data);
    chk("rd lanes", 32'hC, 32'(bq[0]));
    xfer(lds_pkg::LDS_W32, 1'b0, 1'b1, 4'h1, 32'h0);
    chk("burst read", rv(32'h1234ABCD), resp_data);
    $display("t_rd done");
  endtask
  task automatic t_par();
    irq_en <= 1'b1;
    par_en <= 1'b1;
    bad <= 4'h4;
    xfer(lds_pkg::LDS_W32, 1'b0, 1'b0, 4'hF, 32'h0);
    chk("data kept", rv(32'h1234ABCD), resp_data);
    chk("status", 32'h000100C0, status);
    chk("irq", 32'h0, {31'h0, irq_n});
    bad <= 4'h0;
    clr <= 1'b1;
    @(posedge clock);
    clr <= 1'b0;
    par_en <= 1'b0;
    repeat (2) @(posedge clock);
    chk("cleared", 32'h00010000, status);
    bad <= 4'h1;
    xfer(lds_pkg::LDS_W32, 1'b0, 1'b0, 4'hF, 32'h0);
    chk("masked flag", 32'h00010080, status);
    chk("masked irq", 32'h1, {31'h0, irq_n});
    bad <= 4'h0;
    $display("t_par done");
  endtask
  // wait states, ack enable and the endian pin
  task automatic t_cfg();
    burst_cfg <= '{prefetch: 1'b0, read_ahead: 1'b0, ta_enable: 1'b0, continuous: 1'b0, wait_count: 4'h3};
    xfer(lds_pkg::LDS_W32, 1'b0, 1'b1, 4'hF, 32'h0);
    chk("wait cycles", 32'h7, 32'(nk));
    chk("wait data", rv(32'h1234ABCD), resp_data);
    burst_cfg <= '{prefetch: 1'b0, read_ahead: 1'b0, ta_enable: 1'b1, continuous: 1'b0, wait_count: 4'h3};
    xfer(lds_pkg::LDS_W32, 1'b0, 1'b1, 4'hF, 32'h0);
    chk("ack cycles", 32'h4, 32'(nk));
    burst_cfg <= '0;
    pin_n <= 1'b0;
    repeat (6) @(posedge clock);
    xfer(lds_pkg::LDS_W32, 1'b1, 1'b0, 4'hF, 32'hA5C33C5A);
    chk("pin big", rv(32'h5A3CC3A5), pq[0]);
    pin_n <= 1'b1;
    repeat (6) @(posedge clock);
    $display("t_cfg done");
  endtask
  initial
  begin
    forever #10 clock = ~clock;
  end
  // hang guard; a full run needs well under a thousand cycles
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_count++;
      report_and_stop();
    end
  end
  initial
  begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_wr32();
    t_narrow();
    t_rd();
    t_par();
    t_cfg();
    report_and_stop();
  end
endmodule
`default_nettype wire
